/* common/tdsc_pkg.sv */
// Shared constants and types for the transmitter drive shaping control block
package tdsc_pkg;

  // ==========================================================
  // Register map (byte addresses on the AXI4-Lite slave)
  localparam logic [3:0] TDSC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] TDSC_ADDR_OVER = 4'h4;
  localparam logic [3:0] TDSC_ADDR_UNDER = 4'h8;
  localparam logic [3:0] TDSC_ADDR_DISP = 4'hc;
  localparam logic [31:0] TDSC_CTRL_WMASK = 32'h00000fff;
  localparam logic [31:0] TDSC_SHAPE_WMASK = 32'h00033fff;
  localparam logic [31:0] TDSC_CTRL_RESET = 32'h00000000;
  localparam logic [31:0] TDSC_SHAPE_RESET = 32'h00000000;

  // ==========================================================
  // Field positions, control register
  localparam int TDSC_CTRL_EN = 0;
  localparam int TDSC_CTRL_LOWSUP = 1;
  localparam int TDSC_CTRL_DOFF = 2;
  localparam int TDSC_CTRL_MANSEL = 3;
  localparam int TDSC_CTRL_CODE_LSB = 4;
  localparam int TDSC_CTRL_DEPTH_LSB = 8;

  // Field positions, shaping registers and display register
  localparam int TDSC_PAT_W = 14;
  localparam int TDSC_SEL_LSB = 16;
  localparam int TDSC_DISP_OPER = 4;
  localparam int TDSC_DISP_SHAPE = 5;
  localparam int TDSC_DISP_MV_LSB = 8;

  // ==========================================================
  // Regulator voltage mapping in millivolts
  localparam logic [12:0] TDSC_MV_BASE_5V = 13'd3600;
  localparam logic [12:0] TDSC_MV_STEP_5V = 13'd120;
  localparam logic [12:0] TDSC_MV_BASE_3V = 13'd2400;
  localparam logic [12:0] TDSC_MV_STEP_3V = 13'd100;
  localparam logic [12:0] TDSC_MV_MAX_3V = 13'd3600;

  // AXI response codes
  localparam logic [1:0] TDSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] TDSC_RESP_SLVERR = 2'h2;

  // Alternative drive levels chosen by the shaping drive select
  typedef enum logic [1:0] {
    TDSC_DRV_REF = 2'h0,
    TDSC_DRV_MOD = 2'h1,
    TDSC_DRV_STOP = 2'h2,
    TDSC_DRV_RSVD = 2'h3
  } tdsc_drive_type;

  // Shaping sequencer states
  typedef enum logic [2:0] {
    TDSC_SH_IDLE = 3'b001,
    TDSC_SH_OVER = 3'b010,
    TDSC_SH_UNDER = 3'b100
  } tdsc_shape_state_type;

endpackage

/* design/tdsc_shaper.sv */
// Overshoot and undershoot pattern sequencer
`timescale 1ns/1ps
`default_nettype none

module tdsc_shaper #(
  parameter int PAT_W = tdsc_pkg::TDSC_PAT_W
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_modulated,
  input wire logic [PAT_W-1:0] i_over_pattern,
  input wire logic [1:0] i_over_sel,
  input wire logic [PAT_W-1:0] i_under_pattern,
  input wire logic [1:0] i_under_sel,
  output logic o_alt_active,
  output logic [1:0] o_alt_sel,
  output logic o_busy
);
  import tdsc_pkg::*;

  localparam int CW = $clog2(PAT_W + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(PAT_W);

  tdsc_shape_state_type state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic mod_prev_r, mod_prev_nxt;
  logic alt_r, alt_nxt;
  logic [1:0] sel_r, sel_nxt;
  logic [PAT_W-1:0] pat;
  logic [1:0] sel;
  logic [CW-1:0] idx;

  // =========================================================
  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    mod_prev_nxt = i_modulated;
    pat = i_over_pattern;
    sel = i_over_sel;
    idx = cnt_r;
    alt_nxt = 1'b0;
    sel_nxt = sel_r;
    // Any edge restarts from bit 0, even mid pattern
    if (i_modulated != mod_prev_r) begin
      state_nxt = i_modulated ? TDSC_SH_UNDER : TDSC_SH_OVER;
      idx = '0;
    end
    // Undershoot has its own pattern and select
    if (state_nxt == TDSC_SH_UNDER) begin
      pat = i_under_pattern;
      sel = i_under_sel;
    end
    case (state_nxt)
      TDSC_SH_OVER, TDSC_SH_UNDER: begin
        if (idx == CNT_LAST) begin
          // Fifteenth cycle on: regular driver settings
          state_nxt = TDSC_SH_IDLE;
          cnt_nxt = '0;
        end else begin
          // LSB first, one bit per cycle
          // Zero pattern keeps normal drive throughout
          // Reserved select keeps normal drive too
          alt_nxt = pat[idx[CW-1:0]] && (sel != TDSC_DRV_RSVD);
          // One select for the whole pattern
          sel_nxt = sel;
          cnt_nxt = idx + CW'(1);
        end
      end
      TDSC_SH_IDLE: begin
        cnt_nxt = '0;
      end
      default: begin
        state_nxt = TDSC_SH_IDLE;
        cnt_nxt = '0;
      end
    endcase
  end

  // Registers; clock enable freezes everything
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= TDSC_SH_IDLE;
      cnt_r <= '0;
      mod_prev_r <= 1'b0;
      alt_r <= 1'b0;
      sel_r <= TDSC_DRV_REF;
    end else if (i_ce) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      mod_prev_r <= mod_prev_nxt;
      alt_r <= alt_nxt;
      sel_r <= sel_nxt;
    end
  end

  assign o_alt_active = alt_r;
  assign o_alt_sel = sel_r;
  assign o_busy = (state_r != TDSC_SH_IDLE);

endmodule

`default_nettype wire

/* design/tdsc_top.sv */
// Drive shaping and regulator control with an AXI4-Lite register slave
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - All-zero pattern gives normal drive on every cycle after an edge.
// - Select 00b: each set pattern bit drives outputs at driver reference.
// - Select 01b: each set bit drives outputs at modulation supply.
// - Select 10b: each set pattern bit stops the outputs, like a pause.
// - One select value governs all set bits; no per-bit choice.
// - After leaving modulation, 14 bits LSB first, one per cycle.
// - From cycle fifteen on, regular drive settings until next transition.
// - Same sequence with own pattern and select after entering modulation.
// - Manual select 0 uses adjust result; 1 uses the 4-bit manual code.
// - Code maps 3.6-5.4 V by 120 mV, or 2.4-3.6 V by 100 mV.
// - Read-only display of actual regulated code while operating.
// - Four-bit depth code selects modulation over sixteen steps.
// - A bit switches off the digital supply regulator.
// - Supply mode defaults to 5 V; host sets it for 3.3 V.
// - Regulators run only while the operation enable bit is high.
module tdsc_top (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // AXI4-Lite slave
  input wire logic [3:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [3:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Carrier state and adjust-regulators result
  input wire logic i_modulated,
  input wire logic i_adj_done,
  input wire logic [3:0] i_adj_code,
  // Analog driver and regulator controls
  output logic o_alt_active,
  output tdsc_pkg::tdsc_drive_type o_alt_sel,
  output logic o_reg_rf_en,
  output logic o_reg_am_en,
  output logic o_reg_a_en,
  output logic o_reg_d_en,
  output logic o_low_supply_mode,
  output logic [3:0] o_reg_code,
  output logic [12:0] o_reg_mv,
  output logic [3:0] o_modulation_depth_code
);
  import tdsc_pkg::*;

  // =========================================================
  // Register and bus state
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] over_r, over_nxt;
  logic [31:0] under_r, under_nxt;
  logic [3:0] adj_r, adj_nxt;
  logic [3:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic aw_full_r, aw_full_nxt;
  logic w_full_r, w_full_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] bmask;
  logic [31:0] disp;
  logic do_write;

  // Analog control registers
  logic rf_en_r, rf_en_nxt;
  logic am_en_r, am_en_nxt;
  logic a_en_r, a_en_nxt;
  logic d_en_r, d_en_nxt;
  logic lowsup_r, lowsup_nxt;
  logic [3:0] code_r, code_nxt;
  logic [12:0] mv_r, mv_nxt;
  logic [3:0] depth_r, depth_nxt;
  logic [12:0] mv_calc;
  logic [3:0] code_sel;
  logic shaper_busy;
  logic [1:0] alt_sel;

  // =========================================================
  // Shaping sequencer
  tdsc_shaper #(
    .PAT_W(TDSC_PAT_W)
  ) u_shaper (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_modulated(i_modulated),
    .i_over_pattern(over_r[TDSC_PAT_W-1:0]),
    .i_over_sel(over_r[TDSC_SEL_LSB+:2]),
    .i_under_pattern(under_r[TDSC_PAT_W-1:0]),
    .i_under_sel(under_r[TDSC_SEL_LSB+:2]),
    .o_alt_active(o_alt_active),
    .o_alt_sel(alt_sel),
    .o_busy(shaper_busy)
  );

  // =========================================================
  // Regulator setting selection
  always_comb begin
    // Manual code or adjust result
    code_sel = ctrl_r[TDSC_CTRL_MANSEL] ? ctrl_r[TDSC_CTRL_CODE_LSB+:4]
                                        : adj_r;
    // Voltage per supply mode
    if (ctrl_r[TDSC_CTRL_LOWSUP]) begin
      mv_calc = TDSC_MV_BASE_3V + 13'(TDSC_MV_STEP_3V * code_sel);
      // Upper codes would exceed the low-voltage device limit
      if (mv_calc > TDSC_MV_MAX_3V) begin
        mv_calc = TDSC_MV_MAX_3V;
      end
    end else begin
      mv_calc = TDSC_MV_BASE_5V + 13'(TDSC_MV_STEP_5V * code_sel);
    end
    disp = '0;
    // Actual regulated setting, zero when powered down except the shaping busy bit
    if (ctrl_r[TDSC_CTRL_EN]) begin
      disp[3:0] = code_sel;
      disp[TDSC_DISP_OPER] = 1'b1;
      disp[TDSC_DISP_MV_LSB+:13] = mv_calc;
    end
    disp[TDSC_DISP_SHAPE] = shaper_busy;
  end

  // Analog control next values
  always_comb begin
    // All regulators only while enabled
    rf_en_nxt = ctrl_r[TDSC_CTRL_EN];
    am_en_nxt = ctrl_r[TDSC_CTRL_EN];
    a_en_nxt = ctrl_r[TDSC_CTRL_EN];
    // Digital regulator may be off for an external short
    d_en_nxt = ctrl_r[TDSC_CTRL_EN] & ~ctrl_r[TDSC_CTRL_DOFF];
    // Resets to 5 V mode
    lowsup_nxt = ctrl_r[TDSC_CTRL_LOWSUP];
    code_nxt = code_sel;
    mv_nxt = mv_calc;
    // Sixteen-step depth code straight to the modulation regulator
    depth_nxt = ctrl_r[TDSC_CTRL_DEPTH_LSB+:4];
    // Latest adjust-regulators result, used in automatic mode
    adj_nxt = i_adj_done ? i_adj_code : adj_r;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rf_en_r <= 1'b0;
      am_en_r <= 1'b0;
      a_en_r <= 1'b0;
      d_en_r <= 1'b0;
      lowsup_r <= 1'b0;
      code_r <= '0;
      mv_r <= '0;
      depth_r <= '0;
      adj_r <= '0;
    end else if (i_ce) begin
      rf_en_r <= rf_en_nxt;
      am_en_r <= am_en_nxt;
      a_en_r <= a_en_nxt;
      d_en_r <= d_en_nxt;
      lowsup_r <= lowsup_nxt;
      code_r <= code_nxt;
      mv_r <= mv_nxt;
      depth_r <= depth_nxt;
      adj_r <= adj_nxt;
    end
  end

  // =========================================================
  // AXI4-Lite slave next state
  // Address and data are captured independently, so the master may
  // present them in either order; the write lands one cycle later.
  always_comb begin
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    ctrl_nxt = ctrl_r;
    over_nxt = over_r;
    under_nxt = under_r;
    bmask = '0;
    do_write = aw_full_r & w_full_r & ~bvalid_r;
    if (awready_r && i_awvalid) begin
      awaddr_nxt = i_awaddr;
      aw_full_nxt = 1'b1;
    end
    if (wready_r && i_wvalid) begin
      wdata_nxt = i_wdata;
      wstrb_nxt = i_wstrb;
      w_full_nxt = 1'b1;
    end
    for (int b = 0; b < 4; b++) begin
      bmask[8*b+:8] = {8{wstrb_r[b]}};
    end
    if (bvalid_r && i_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_write) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = TDSC_RESP_OKAY;
      case (awaddr_r)
        TDSC_ADDR_CTRL: begin
          ctrl_nxt = ((ctrl_r & ~bmask) | (wdata_r & bmask))
                     & TDSC_CTRL_WMASK;
        end
        TDSC_ADDR_OVER: begin
          over_nxt = ((over_r & ~bmask) | (wdata_r & bmask))
                     & TDSC_SHAPE_WMASK;
        end
        TDSC_ADDR_UNDER: begin
          under_nxt = ((under_r & ~bmask) | (wdata_r & bmask))
                      & TDSC_SHAPE_WMASK;
        end
        TDSC_ADDR_DISP: begin
          bresp_nxt = TDSC_RESP_OKAY;
        end
        default: begin
          bresp_nxt = TDSC_RESP_SLVERR;
        end
      endcase
    end
    // Ready falls once a beat is held, until the response is taken
    awready_nxt = ~aw_full_nxt & ~bvalid_nxt;
    wready_nxt = ~w_full_nxt & ~bvalid_nxt;
  end

  // Read channel: one read outstanding, data taken at the handshake
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && i_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (arready_r && i_arvalid) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = TDSC_RESP_OKAY;
      case (i_araddr)
        TDSC_ADDR_CTRL: rdata_nxt = ctrl_r;
        TDSC_ADDR_OVER: rdata_nxt = over_r;
        TDSC_ADDR_UNDER: rdata_nxt = under_r;
        TDSC_ADDR_DISP: rdata_nxt = disp;
        default: begin
          rdata_nxt = '0;
          rresp_nxt = TDSC_RESP_SLVERR;
        end
      endcase
    end
    arready_nxt = ~rvalid_nxt;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r <= TDSC_CTRL_RESET;
      over_r <= TDSC_SHAPE_RESET;
      under_r <= TDSC_SHAPE_RESET;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= TDSC_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= TDSC_RESP_OKAY;
    end else if (i_ce) begin
      ctrl_r <= ctrl_nxt;
      over_r <= over_nxt;
      under_r <= under_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // =========================================================
  // Output wiring, all from flip-flops
  assign o_awready = awready_r;
  assign o_wready = wready_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_arready = arready_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
  assign o_reg_rf_en = rf_en_r;
  assign o_reg_am_en = am_en_r;
  assign o_reg_a_en = a_en_r;
  assign o_reg_d_en = d_en_r;
  assign o_low_supply_mode = lowsup_r;
  assign o_reg_code = code_r;
  assign o_reg_mv = mv_r;
  assign o_modulation_depth_code = depth_r;
  // Plain select bits from the sequencer register, typed at the boundary
  assign o_alt_sel = tdsc_drive_type'(alt_sel);

endmodule

`default_nettype wire

/* bench/tdsc_props.sv */
// Port-level assertions for the drive shaping control block
`timescale 1ns/1ps
`default_nettype none

module tdsc_props (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  input wire logic i_modulated,
  input wire logic o_alt_active,
  input wire tdsc_pkg::tdsc_drive_type o_alt_sel,
  input wire logic o_reg_rf_en,
  input wire logic o_reg_am_en,
  input wire logic o_reg_a_en,
  input wire logic o_reg_d_en,
  input wire logic o_low_supply_mode,
  input wire logic [3:0] o_reg_code,
  input wire logic [12:0] o_reg_mv
);
  import tdsc_pkg::*;

  logic mod_q_r;
  logic mod_q_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // ==========================================================
  // Cycles since the last carrier transition, saturating at 15
  always_comb begin
    mod_q_nxt = mod_q_r;
    cnt_nxt = cnt_r;
    if (i_ce) begin
      mod_q_nxt = i_modulated;
      if (i_modulated != mod_q_r) begin
        cnt_nxt = 4'h0;
      end else if (cnt_r != 4'hf) begin
        cnt_nxt = cnt_r + 4'h1;
      end
    end
  end

  // Idle count at reset so no pattern is expected before a transition
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mod_q_r <= 1'b0;
      cnt_r <= 4'hf;
    end else begin
      mod_q_r <= mod_q_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // Shaping, regulator and bus relations
  chk_alt_late_off: assert property (
    cnt_r >= 4'he |-> !o_alt_active)
    else $error("alt drive active after pattern end");
  chk_alt_sel_legal: assert property (
    o_alt_active |-> o_alt_sel != TDSC_DRV_RSVD)
    else $error("alt drive with reserved select");
  chk_alt_sel_held: assert property (
    o_alt_active && $past(o_alt_active) && cnt_r != 4'h0
    |-> $stable(o_alt_sel))
    else $error("select changed within one pattern");
  chk_dreg_off: assert property (
    o_reg_d_en |-> o_reg_a_en && o_reg_rf_en && o_reg_am_en)
    else $error("digital regulator on without enable");
  chk_regs_same: assert property (
    o_reg_rf_en == o_reg_am_en && o_reg_rf_en == o_reg_a_en)
    else $error("regulator enables disagree");
  chk_mv_five: assert property (
    o_reg_rf_en && !o_low_supply_mode
    |-> o_reg_mv == TDSC_MV_BASE_5V + TDSC_MV_STEP_5V * o_reg_code)
    else $error("5 V voltage mapping wrong");
  chk_mv_low: assert property (
    o_reg_rf_en && o_low_supply_mode
    |-> o_reg_mv == ((o_reg_code > 4'hc) ? TDSC_MV_MAX_3V
                     : TDSC_MV_BASE_3V + TDSC_MV_STEP_3V * o_reg_code))
    else $error("low supply voltage mapping wrong");
  chk_b_hold: assert property (
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  chk_rd_answer: assert property (
    i_ce && i_arvalid && o_arready |=> o_rvalid)
    else $error("read not answered next cycle");
endmodule

bind tdsc_top tdsc_props u_props (.i_ref_clk, .i_rst_n, .i_ce, .i_arvalid,
  .o_arready, .o_rvalid, .i_rready, .o_rdata, .o_bvalid, .i_bready, .o_bresp,
  .i_modulated, .o_alt_active, .o_alt_sel, .o_reg_rf_en, .o_reg_am_en,
  .o_reg_a_en, .o_reg_d_en, .o_low_supply_mode, .o_reg_code, .o_reg_mv);

`default_nettype wire

/* bench/tdsc_adjust_model.sv */
// Adjust-regulators result source standing beside the block
`timescale 1ns/1ps
`default_nettype none

module tdsc_adjust_model #(
  parameter int LAT = 3
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [3:0] i_code,
  output logic o_adj_done,
  output logic [3:0] o_adj_code
);
  logic [3:0] code_r;
  int cnt_r;

  // Result comes some cycles after the request, as one pulse
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 0;
      code_r <= 4'h0;
      o_adj_done <= 1'b0;
    end else begin
      o_adj_done <= (cnt_r == 1);
      if (i_start) begin
        cnt_r <= LAT;
        code_r <= i_code;
      end else if (cnt_r != 0) begin
        cnt_r <= cnt_r - 1;
      end
    end
  end

  // Code bus is garbage outside the pulse, so a late capture shows up
  assign o_adj_code = o_adj_done ? code_r : ~code_r;
endmodule

`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the drive shaping control block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import tdsc_pkg::*;

  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_ce = 1'b1;
  logic [3:0] i_awaddr = 4'h0;
  logic i_awvalid = 1'b0;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'hf;
  logic i_wvalid = 1'b0;
  logic i_bready = 1'b0;
  logic [3:0] i_araddr = 4'h0;
  logic i_arvalid = 1'b0;
  logic i_rready = 1'b0;
  logic i_modulated = 1'b0;
  logic i_adj_done;
  logic [3:0] i_adj_code;
  logic adj_go = 1'b0;
  logic [3:0] adj_c = 4'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_alt_active;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  tdsc_drive_type o_alt_sel;
  logic o_reg_rf_en, o_reg_am_en, o_reg_a_en, o_reg_d_en, o_low_supply_mode;
  logic [3:0] o_reg_code, o_modulation_depth_code;
  logic [12:0] o_reg_mv;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [1:0] r;
  logic [15:0] tr;
  logic ok;
  logic [1:0] sl;
  logic [13:0] po [5] = '{14'h2a5b, 14'h0001, 14'h3ffe, 14'h2001, 14'h0};
  logic [13:0] pu [5] = '{14'h15a4, 14'h3fff, 14'h2000, 14'h1111, 14'h0};

  // ==========================================================
  // Clock, design and adjust source
  always #12.5 i_ref_clk = ~i_ref_clk;

  tdsc_top dut (.i_ref_clk, .i_rst_n, .i_ce, .i_awaddr, .i_awvalid,
    .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
    .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
    .o_rvalid, .i_rready, .i_modulated, .i_adj_done, .i_adj_code,
    .o_alt_active, .o_alt_sel, .o_reg_rf_en, .o_reg_am_en, .o_reg_a_en,
    .o_reg_d_en, .o_low_supply_mode, .o_reg_code, .o_reg_mv,
    .o_modulation_depth_code);

  tdsc_adjust_model #(.LAT(3)) u_adj (.i_ref_clk, .i_rst_n, .i_start(adj_go),
    .i_code(adj_c), .o_adj_done(i_adj_done), .o_adj_code(i_adj_code));

  // Hang guard, the whole run needs well under a thousand cycles
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end

  // ==========================================================
  // Reporting and comparisons
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t word %h want %h", $time, got, exp);
    end
  endtask

  task automatic cmp_trace(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t trace %h want %h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // AXI4-Lite master; ready is looked at mid-cycle, where it is settled
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] resp);
    logic aw_hit, w_hit, b_hit, b_seen;
    b_hit = 1'b0;
    b_seen = 1'b0;
    @(posedge i_ref_clk);
    i_awaddr <= a;
    i_awvalid <= 1'b1;
    i_wdata <= d;
    i_wvalid <= 1'b1;
    while (!b_hit) begin
      @(negedge i_ref_clk);
      aw_hit = i_awvalid && o_awready;
      w_hit = i_wvalid && o_wready;
      b_hit = o_bvalid && i_bready;
      b_seen = o_bvalid;
      resp = o_bresp;
      @(posedge i_ref_clk);
      if (aw_hit) i_awvalid <= 1'b0;
      if (w_hit) i_wvalid <= 1'b0;
      // Response left waiting a cycle so the hold checks see a stall
      if (b_seen && !b_hit) i_bready <= 1'b1;
    end
    i_bready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp,
                        input logic [1:0] exp_r);
    logic ar_hit, r_hit, r_seen;
    logic [31:0] d;
    logic [1:0] rr;
    r_hit = 1'b0;
    r_seen = 1'b0;
    @(posedge i_ref_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    while (!r_hit) begin
      @(negedge i_ref_clk);
      ar_hit = i_arvalid && o_arready;
      r_hit = o_rvalid && i_rready;
      r_seen = o_rvalid;
      d = o_rdata;
      rr = o_rresp;
      @(posedge i_ref_clk);
      if (ar_hit) i_arvalid <= 1'b0;
      if (r_seen && !r_hit) i_rready <= 1'b1;
    end
    i_rready <= 1'b0;
    cmp_word(d, exp);
    cmp_word({30'h0, rr}, {30'h0, exp_r});
  endtask

  // Control write, then the analog side two cycles later
  task automatic reg_chk(input logic [31:0] c, input logic [12:0] mv,
    input logic [3:0] code, input logic [3:0] dep, input logic low,
    input logic [3:0] ens);
    axi_wr(TDSC_ADDR_CTRL, c, r);
    repeat (2) @(posedge i_ref_clk);
    #1;
    cmp_word({6'h0, o_reg_mv, o_reg_code, o_modulation_depth_code,
      o_low_supply_mode, o_reg_rf_en, o_reg_am_en, o_reg_a_en, o_reg_d_en},
      {6'h0, mv, code, dep, low, ens});
  endtask

  // Carrier change, then one sample of the alt drive per cycle
  task automatic shape(input logic v, input int n, input logic [1:0] s,
                       output logic [15:0] t, output logic good);
    t = 16'h0;
    good = 1'b1;
    @(posedge i_ref_clk);
    i_modulated <= v;
    for (int k = 0; k < n; k++) begin
      @(posedge i_ref_clk);
      #1;
      t[k] = o_alt_active;
      if (o_alt_active === 1'b1 && o_alt_sel !== tdsc_drive_type'(s)) begin
        good = 1'b0;
      end
    end
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    repeat (6) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd_chk(TDSC_ADDR_CTRL, TDSC_CTRL_RESET,
      TDSC_RESP_OKAY);
    rd_chk(TDSC_ADDR_OVER, TDSC_SHAPE_RESET, TDSC_RESP_OKAY);
    rd_chk(TDSC_ADDR_DISP, 32'h0, TDSC_RESP_OKAY);
    cmp_word({28'h0, o_reg_rf_en, o_reg_am_en, o_reg_a_en, o_reg_d_en},
      0);
    $display("test reset done");
    axi_wr(TDSC_ADDR_OVER, 32'hffffffff, r);
    rd_chk(TDSC_ADDR_OVER, TDSC_SHAPE_WMASK, TDSC_RESP_OKAY);
    axi_wr(TDSC_ADDR_DISP, 32'hffffffff, r);
    cmp_word({30'h0, r}, {30'h0, TDSC_RESP_OKAY});
    rd_chk(TDSC_ADDR_DISP, 32'h0, TDSC_RESP_OKAY);
    axi_wr(4'h2, 32'h1, r);
    cmp_word({30'h0, r}, {30'h0, TDSC_RESP_SLVERR});
    rd_chk(4'h6, 32'h0, TDSC_RESP_SLVERR);
    $display("test access done");
    reg_chk(32'h959, TDSC_MV_BASE_5V + TDSC_MV_STEP_5V * 5, 4'h5, 4'h9, 0,
      4'hf);
    reg_chk(32'h0ff, TDSC_MV_MAX_3V, 4'hf, 4'h0, 1,
      4'he);
    reg_chk(32'h03b, TDSC_MV_BASE_3V + TDSC_MV_STEP_3V * 3, 4'h3, 4'h0, 1,
      4'hf);
    for (int dp = 0; dp < 16; dp++) begin
      reg_chk(32'h009 | (dp << 8), TDSC_MV_BASE_5V, 4'h0, dp[3:0], 0,
        4'hf);
    end
    @(posedge i_ref_clk);
    adj_go <= 1'b1;
    adj_c <= 4'h7;
    @(posedge i_ref_clk);
    adj_go <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    reg_chk(32'h001, TDSC_MV_BASE_5V + TDSC_MV_STEP_5V * 7, 4'h7, 4'h0, 0,
      4'hf);
    rd_chk(TDSC_ADDR_DISP, 32'h17 | (32'(TDSC_MV_BASE_5V
      + TDSC_MV_STEP_5V * 7) << TDSC_DISP_MV_LSB),
      TDSC_RESP_OKAY);
    axi_wr(TDSC_ADDR_CTRL, 32'h0, r);
    repeat (2) @(posedge i_ref_clk);
    #1;
    cmp_word({28'h0, o_reg_rf_en, o_reg_am_en, o_reg_a_en, o_reg_d_en},
      0);
    rd_chk(TDSC_ADDR_DISP, 32'h0, TDSC_RESP_OKAY);
    $display("test regulator done");
    for (int s = 0; s < 5; s++) begin
      sl = (s == 4) ? 2'h1 : s[1:0];
      axi_wr(TDSC_ADDR_OVER, {14'h0, sl, 2'h0, po[s]}, r);
      axi_wr(TDSC_ADDR_UNDER, {14'h0, sl, 2'h0, pu[s]}, r);
      shape(1'b1, 16, sl, tr, ok);
      cmp_trace(tr, (sl == 2'h3) ? 16'h0
        : {2'h0, pu[s]});
      cmp_word({31'h0, ok}, 32'h1);
      shape(1'b0, 16, sl, tr, ok);
      cmp_trace(tr, (sl == 2'h3) ? 16'h0
        : {2'h0, po[s]});
      cmp_word({31'h0, ok}, 32'h1);
    end
    $display("test shaping done");
    axi_wr(TDSC_ADDR_OVER, {14'h0, 2'h0, 2'h0, 14'h3fff}, r);
    axi_wr(TDSC_ADDR_UNDER, {14'h0, 2'h1, 2'h0, 14'h0001}, r);
    shape(1'b1, 16, 2'h1, tr, ok);
    shape(1'b0, 5, 2'h0, tr, ok);
    cmp_trace(tr, 16'h001f);
    shape(1'b1, 16, 2'h1, tr, ok);
    cmp_trace(tr, 16'h0001);
    $display("test restart done");
    finish_test();
  end
endmodule

`default_nettype wire
